// file: rtl/iml_sync.sv
/*
 * Three-stage input filter for pins from outside the clock domain.
 * Assumes a synchronous active-high reset; the output only moves
 * once the second and third stages agree.
 */
`timescale 1ns/1ps

module iml_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;

	assign agree = ~(s2_r ^ s3_r);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q    <= '0;
		end
		else
		begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Per bit: only a settled level passes
			q    <= (agree & s3_r) | (~agree & q);
		end
	end
endmodule : iml_sync

// file: rtl/iml_top.sv
/*
 * Interrupt mask, restart 7.5 edge latch, enable status and serial
 * output latch, reached over AXI4-Lite. A write to the set-masks word
 * executes set-masks with the low byte as accumulator; a read of the
 * read-masks word executes read-masks. Trap and acknowledge pulses come
 * from core logic on the same clock; pins pass a three-stage filter.
 */
`timescale 1ns/1ps

`include "iml_regs.svh"

module iml_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic              RST55_IN,
	input  wire logic              RST65_IN,
	input  wire logic              RST75_IN,
	input  wire logic              SERIAL_IN,
	input  wire logic              TRAP_TAKEN,
	input  wire logic              VEC_TAKEN,
	input  wire logic              ACK75,
	output logic                   SERIAL_OUT,
	output logic [2:0]             MASK_OUT,
	output logic                   EDGE75_OUT,
	output logic                   INT_EN_OUT,
	output logic                   IRQ
);
	// Filtered pin levels
	logic [3:0]        pins_q;
	logic              lvl55;
	logic              lvl65;
	logic              lvl75;
	logic              lvl_sid;

	iml_sync #(
		.W (4)
	) u_sync (
		.clk (CLK),
		.rst (SYS_RST),
		.d   ({SERIAL_IN, RST75_IN, RST65_IN, RST55_IN}),
		.q   (pins_q)
	);

	assign lvl55   = pins_q[0];
	assign lvl65   = pins_q[1];
	assign lvl75   = pins_q[2];
	assign lvl_sid = pins_q[3];

	// Block state
	logic [2:0]        mask_r;
	logic [2:0]        mask_nxt;
	logic              e75_r;
	logic              e75_nxt;
	logic              sod_r;
	logic              sod_nxt;
	logic              ie_r;
	logic              ie_nxt;
	logic              saved_ie_r;
	logic              saved_ie_nxt;
	logic              trap_r;
	logic              trap_nxt;
	logic [2:0]        prev_r;
	logic [`IML_EV_W-1:0] stat_r;
	logic [`IML_EV_W-1:0] stat_nxt;
	logic [`IML_EV_W-1:0] imsk_r;
	logic [`IML_EV_W-1:0] imsk_nxt;

	// Bus slave state
	logic              aw_have_r;
	logic              aw_have_nxt;
	logic              w_have_r;
	logic              w_have_nxt;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              bvalid_nxt;
	logic              rvalid_nxt;

	// Handshakes
	wire aw_go = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_go  = S_AXI_WVALID & S_AXI_WREADY;
	wire ar_go = S_AXI_ARVALID & S_AXI_ARREADY;
	wire wr_go = aw_have_r & w_have_r & ~S_AXI_BVALID;

	// Write decode, word aligned
	wire [ADDR_W-1:0] wa    = {awaddr_r[ADDR_W-1:2], 2'h0};
	wire              wb0   = wr_go & wstrb_r[0];
	wire              w_setm = (wa == ADDR_W'(`IML_OFF_SETM));
	wire              w_ctrl = (wa == ADDR_W'(`IML_OFF_CTRL));
	wire              w_imsk = (wa == ADDR_W'(`IML_OFF_IMSK));
	wire              w_rdonly = (wa == ADDR_W'(`IML_OFF_READM))
	                            | (wa == ADDR_W'(`IML_OFF_STAT));
	wire              w_hit  = w_setm | w_ctrl | w_imsk | w_rdonly;
	wire [7:0]        acc_w  = wdata_r[7:0];

	wire do_setm = wb0 & w_setm;
	wire do_ctrl = wb0 & w_ctrl;
	wire do_imsk = wb0 & w_imsk;

	// Read decode
	wire [ADDR_W-1:0] ra     = {S_AXI_ARADDR[ADDR_W-1:2], 2'h0};
	wire              r_setm = (ra == ADDR_W'(`IML_OFF_SETM));
	wire              r_rdm  = (ra == ADDR_W'(`IML_OFF_READM));
	wire              r_ctrl = (ra == ADDR_W'(`IML_OFF_CTRL));
	wire              r_stat = (ra == ADDR_W'(`IML_OFF_STAT));
	wire              r_imsk = (ra == ADDR_W'(`IML_OFF_IMSK));
	wire              r_hit  = r_setm | r_rdm | r_ctrl | r_stat | r_imsk;
	wire              do_rdm  = ar_go & r_rdm;
	wire              do_rstat = ar_go & r_stat;

	// Set-masks effects
	wire mask_load = do_setm & acc_w[`IML_ACC_MSE];
	wire e75_clr_sw = do_setm & acc_w[`IML_ACC_R75];
	wire sod_load  = do_setm & acc_w[`IML_ACC_SOE];

	// Edges of the filtered request pins
	wire rise55 = lvl55 & ~prev_r[0];
	wire rise65 = lvl65 & ~prev_r[1];
	wire rise75 = lvl75 & ~prev_r[2];

	// Acknowledge only clears once the mask has been lifted
	wire e75_clr_ack = ACK75 & ~mask_r[2];

	// Edge sets regardless of mask, and beats any clear
	assign e75_nxt = rise75 | (e75_r & ~(e75_clr_sw | e75_clr_ack));

	assign mask_nxt = mask_load ? acc_w[`IML_ACC_M75:`IML_ACC_M55] : mask_r;
	assign sod_nxt  = sod_load ? acc_w[`IML_ACC_SOD] : sod_r;

	// Enable flag: trap and vectored interrupts both drop it
	always_comb
	begin
		ie_nxt = ie_r;
		if (do_ctrl)
			ie_nxt = wdata_r[`IML_CTRL_IE];
		if (TRAP_TAKEN | VEC_TAKEN)
			ie_nxt = 1'h0;
	end

	// Pre-trap enable is kept until read-masks or another interrupt
	assign saved_ie_nxt = TRAP_TAKEN ? ie_r : saved_ie_r;
	// Later vectored interrupts show the live flag again
	assign trap_nxt = TRAP_TAKEN | (trap_r & ~do_rdm & ~VEC_TAKEN);

	// Read-masks image
	logic [7:0] read_masks_instr;
	always_comb
	begin
		read_masks_instr = 8'h00;
		read_masks_instr[`IML_ACC_M75:`IML_ACC_M55] = mask_r;
		read_masks_instr[`IML_ACC_IE] = trap_r ? saved_ie_r : ie_r;
		read_masks_instr[`IML_ACC_P55] = lvl55;
		read_masks_instr[`IML_ACC_P65] = lvl65;
		read_masks_instr[`IML_ACC_I75] = e75_r;
		read_masks_instr[`IML_ACC_SID] = lvl_sid;
	end

	// Sticky events; a read clears, but a new event in that cycle stays
	wire [`IML_EV_W-1:0] ev_set = {rise65, rise55, TRAP_TAKEN, rise75};
	wire [`IML_EV_W-1:0] ev_clr = do_rstat ? stat_r : '0;
	assign stat_nxt = (stat_r & ~ev_clr) | ev_set;
	assign imsk_nxt = do_imsk ? wdata_r[`IML_EV_W-1:0] : imsk_r;

	// Read data mux
	wire [31:0] rd_setm = {24'h0, sod_r, 4'h0, mask_r};
	wire [31:0] rd_ctrl = {31'h0, ie_r};
	wire [31:0] rd_stat = {{(32-`IML_EV_W){1'h0}}, stat_r};
	wire [31:0] rd_imsk = {{(32-`IML_EV_W){1'h0}}, imsk_r};
	wire [31:0] rd_mux  = r_setm ? rd_setm :
	                      r_rdm  ? {24'h0, read_masks_instr} :
	                      r_ctrl ? rd_ctrl :
	                      r_stat ? rd_stat :
	                      r_imsk ? rd_imsk : 32'h0;

	// Channel bookkeeping
	assign aw_have_nxt = (aw_have_r | aw_go) & ~wr_go;
	assign w_have_nxt  = (w_have_r | w_go) & ~wr_go;
	assign bvalid_nxt  = wr_go | (S_AXI_BVALID & ~S_AXI_BREADY);
	assign rvalid_nxt  = ar_go | (S_AXI_RVALID & ~S_AXI_RREADY);

	// Bus slave registers
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			aw_have_r     <= 1'h0;
			w_have_r      <= 1'h0;
			awaddr_r      <= '0;
			wdata_r       <= 32'h0;
			wstrb_r       <= 4'h0;
			S_AXI_AWREADY <= 1'h0;
			S_AXI_WREADY  <= 1'h0;
			S_AXI_BVALID  <= 1'h0;
			S_AXI_BRESP   <= iml_pkg::IML_OKAY;
			S_AXI_ARREADY <= 1'h0;
			S_AXI_RVALID  <= 1'h0;
			S_AXI_RDATA   <= 32'h0;
			S_AXI_RRESP   <= iml_pkg::IML_OKAY;
		end
		else
		begin
			aw_have_r     <= aw_have_nxt;
			w_have_r      <= w_have_nxt;
			S_AXI_AWREADY <= ~aw_have_nxt & ~bvalid_nxt;
			S_AXI_WREADY  <= ~w_have_nxt & ~bvalid_nxt;
			S_AXI_BVALID  <= bvalid_nxt;
			S_AXI_ARREADY <= ~rvalid_nxt;
			S_AXI_RVALID  <= rvalid_nxt;
			if (aw_go)
				awaddr_r <= S_AXI_AWADDR;
			if (w_go)
			begin
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
			end
			if (wr_go)
				S_AXI_BRESP <= w_hit ? iml_pkg::IML_OKAY : iml_pkg::IML_SLVERR;
			if (ar_go)
			begin
				S_AXI_RDATA <= rd_mux;
				S_AXI_RRESP <= r_hit ? iml_pkg::IML_OKAY : iml_pkg::IML_SLVERR;
			end
		end
	end

	// Mask, latch and enable state
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			mask_r     <= `IML_MASK_RST;
			e75_r      <= 1'h0;
			sod_r      <= `IML_SOD_RST;
			ie_r       <= `IML_IE_RST;
			saved_ie_r <= `IML_IE_RST;
			trap_r     <= 1'h0;
			prev_r     <= 3'h0;
		end
		else
		begin
			mask_r     <= mask_nxt;
			e75_r      <= e75_nxt;
			sod_r      <= sod_nxt;
			ie_r       <= ie_nxt;
			saved_ie_r <= saved_ie_nxt;
			trap_r     <= trap_nxt;
			prev_r     <= {lvl75, lvl65, lvl55};
		end
	end

	// Interrupt status and pin outputs
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			stat_r     <= '0;
			imsk_r     <= `IML_IMSK_RST;
			IRQ        <= 1'h0;
			SERIAL_OUT <= `IML_SOD_RST;
			MASK_OUT   <= `IML_MASK_RST;
			EDGE75_OUT <= 1'h0;
			INT_EN_OUT <= `IML_IE_RST;
		end
		else
		begin
			stat_r     <= stat_nxt;
			imsk_r     <= imsk_nxt;
			IRQ        <= |(stat_nxt & imsk_nxt);
			// Pin follows the latch with no gap between loads
			SERIAL_OUT <= sod_nxt;
			MASK_OUT   <= mask_nxt;
			EDGE75_OUT <= e75_nxt;
			INT_EN_OUT <= ie_nxt;
		end
	end
endmodule : iml_top

// file: shared/iml_pkg.sv
/*
 * Types shared by the interrupt mask block.
 * Assumes iml_regs.svh sits beside it on the include path.
 */
`include "iml_regs.svh"

package iml_pkg;
	typedef enum logic [1:0]
	{
		IML_OKAY   = 2'h0,
		IML_SLVERR = 2'h2
	} iml_resp_e;

	typedef logic [7:0] iml_acc_t;
endpackage : iml_pkg

// file: shared/iml_regs.svh
/*
 * Constants of the interrupt mask and serial latch block: register byte
 * offsets, accumulator bit positions, reset values and event bit layout.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef IML_REGS_SVH
`define IML_REGS_SVH
// Function
// - Set-masks with bit 3 loads three masks
// - Set-masks with bit 3 low keeps masks
// - Set-masks with bit 4 clears 7.5 latch
// - Every 7.5 rising edge sets latch, masked too
// - 7.5 latch holds until reset, clear, acknowledge; here acknowledge clears it only while the 7.5 mask bit is low
// - Reset sets all three mask bits
// - Set-masks with bit 6 copies bit 7 out
// - Set-masks with bit 6 low keeps serial latch
// - Reset clears serial output latch
// - Read-masks returns the three mask bits
// - Read-masks returns interrupt enable, one enabled
// - After trap, bit 3 returns pre-trap enable
// - After other interrupts, enable shows current state
// - Read-masks bit 6 returns 7.5 latch
// - Read-masks reports pending requests per input
// - Read-masks returns serial input level

`define IML_OFF_SETM	8'h00
`define IML_OFF_READM	8'h04
`define IML_OFF_CTRL	8'h08
`define IML_OFF_STAT	8'h0C
`define IML_OFF_IMSK	8'h10

`define IML_ACC_M55	0
`define IML_ACC_M75	2
`define IML_ACC_MSE	3
`define IML_ACC_R75	4
`define IML_ACC_SOE	6
`define IML_ACC_SOD	7
`define IML_ACC_IE	3
`define IML_ACC_P55	4
`define IML_ACC_P65	5
`define IML_ACC_I75	6
`define IML_ACC_SID	7

`define IML_CTRL_IE	0

`define IML_EV_E75	0
`define IML_EV_TRAP	1
`define IML_EV_P55	2
`define IML_EV_P65	3
`define IML_EV_W	4

`define IML_MASK_RST	3'h7
`define IML_SOD_RST	1'h0
`define IML_IE_RST	1'h0
`define IML_IMSK_RST	4'h0

`endif

// file: sim/iml_pins.sv
/* Far side: interrupt and serial input sources plus a serial output
   listener. Assumes the bench clock; pins are held levels. */
`timescale 1ns/1ps

module iml_pins (
	input  wire logic       clk,
	input  wire logic [3:0] cmd,
	input  wire logic       sout,
	output logic            r55,
	output logic            r65,
	output logic            r75,
	output logic            sin,
	output logic [7:0]      chg
);
	logic sout_r;
	initial
	begin
		{sin, r75, r65, r55} = 4'h0;
		chg = 8'h00;
		sout_r = 1'h0;
	end
	always @(posedge clk)
	begin
		{sin, r75, r65, r55} <= cmd;
		sout_r <= sout;
		// Unknown before reset must not count as a change
		if ((sout ^ sout_r) === 1'h1)
			chg <= chg + 8'h01;
	end
endmodule : iml_pins

// file: sim/iml_props.sv
/* Port checker for iml_top.
   Assumes it is bound to iml_top by the bench. */
`timescale 1ns/1ps

module iml_props (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic [7:0]  S_AXI_AWADDR,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0]  S_AXI_WSTRB,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        RST75_IN,
	input wire logic        ACK75,
	input wire logic        SERIAL_OUT,
	input wire logic [2:0]  MASK_OUT,
	input wire logic        EDGE75_OUT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic       setm;
	logic       exe_r;
	logic [7:0] wd_r;
	logic       keep75;
	// Both channels taken at once: the bench always offers them together
	assign setm = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		&& S_AXI_AWADDR == 8'h00 && S_AXI_WSTRB[0];
	// Set-masks runs one edge after the handshake; outputs show one edge later
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			exe_r <= 1'h0;
		else
			exe_r <= setm;
		if (setm)
			wd_r <= S_AXI_WDATA[7:0];
	end
	assign keep75 = EDGE75_OUT && !ACK75 && !(exe_r && wd_r[4]);
	sequence s_mld; exe_r && wd_r[3]; endsequence
	sequence s_sld; exe_r && wd_r[6]; endsequence

	mask_load_a: assert property (s_mld |=> MASK_OUT == wd_r[2:0])
		else $error("mask not loaded");
	mask_keep_a: assert property (!(exe_r && wd_r[3]) |=> $stable(MASK_OUT))
		else $error("mask moved");
	sod_load_a: assert property (s_sld |=> SERIAL_OUT == wd_r[7])
		else $error("serial latch not loaded");
	sod_keep_a: assert property (!(exe_r && wd_r[6]) |=> $stable(SERIAL_OUT))
		else $error("serial latch moved");
	rst_vals_a: assert property (disable iff (1'h0) SYS_RST |=> MASK_OUT == 3'h7 && !SERIAL_OUT)
		else $error("reset values wrong");
	edge_hold_a: assert property (keep75 |=> EDGE75_OUT)
		else $error("edge latch dropped");
	edge_set_a: assert property ($rose(RST75_IN) |-> ##[3:7] EDGE75_OUT)
		else $error("edge latch not set");
	read_ans_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
endmodule : iml_props

// file: sim/iml_top_bench.sv
/* Bench for iml_top over AXI4-Lite with the pin model.
   Assumes iml_pkg, iml_props and iml_pins compiled first. */
`timescale 1ns/1ps

module iml_top_bench;
	logic        CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
	logic        S_AXI_ARVALID, S_AXI_RREADY, TRAP_TAKEN, VEC_TAKEN, ACK75;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic        S_AXI_RVALID, RST55_IN, RST65_IN, RST75_IN, SERIAL_IN;
	logic        SERIAL_OUT, EDGE75_OUT, INT_EN_OUT, IRQ;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rr, br;
	logic [2:0]  MASK_OUT;
	logic [3:0]  S_AXI_WSTRB, pin_cmd;
	logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, sout_chg;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
	int          error_cnt, samples_checked;

	iml_top iml_top_inst (.*);
	iml_pins iml_pins_inst (.clk(CLK), .cmd(pin_cmd), .sout(SERIAL_OUT), .r55(RST55_IN),
		.r65(RST65_IN), .r75(RST75_IN), .sin(SERIAL_IN), .chg(sout_chg));

	initial CLK = 1'h0;
	always #25 CLK = ~CLK;

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		logic aw, w, b;
		int n;
		aw = 1'h1;
		w = 1'h1;
		b = 1'h0;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h000000, d};
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		for (n = 0; !b; n++)
		begin
			@(posedge CLK);
			b = !aw && !w && S_AXI_BVALID;
			aw = aw && !S_AXI_AWREADY;
			w = w && !S_AXI_WREADY;
			br = S_AXI_BRESP;
			S_AXI_AWVALID <= aw;
			S_AXI_WVALID <= w;
			S_AXI_BREADY <= !b;
			if (n > 40)
			begin
				error_cnt++;
				test_done();
			end
		end
	endtask : axw

	task automatic axr(input logic [7:0] a);
		logic ar, r;
		int n;
		ar = 1'h1;
		r = 1'h0;
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		for (n = 0; !r; n++)
		begin
			@(posedge CLK);
			r = !ar && S_AXI_RVALID;
			ar = ar && !S_AXI_ARREADY;
			rd = S_AXI_RDATA;
			rr = S_AXI_RRESP;
			S_AXI_ARVALID <= ar;
			S_AXI_RREADY <= !r;
			if (n > 40)
			begin
				error_cnt++;
				test_done();
			end
		end
	endtask : axr

	initial
	begin
		{SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h8;
		{S_AXI_ARVALID, S_AXI_RREADY, TRAP_TAKEN, VEC_TAKEN, ACK75} = 5'h00;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
		S_AXI_WSTRB = 4'hF;
		pin_cmd = 4'h0;
		repeat (20) @(posedge CLK);
		chk(MASK_OUT, 3'h7, "mask rst");
		chk(SERIAL_OUT, 1'h0, "sod rst");
		SYS_RST <= 1'h0;
		axr(8'h04);
		chk(rd, 32'h07, "readm rst");
		for (int m = 0; m < 8; m++)
		begin
			axw(8'h00, 8'h08 | m[7:0]);
			chk(MASK_OUT, m[2:0], "mask");
			axr(8'h04);
			chk(rd[2:0], m[2:0], "readm mask");
		end
		axw(8'h00, 8'hC0);
		chk(SERIAL_OUT, 1'h1, "sod set");
		axw(8'h00, 8'h00);
		chk(SERIAL_OUT, 1'h1, "sod keep");
		chk(MASK_OUT, 3'h7, "mask keep");
		axw(8'h00, 8'h40);
		chk(SERIAL_OUT, 1'h0, "sod clr");
		axw(8'h10, 8'h01);
		// Listener counts a change one edge late
		chk(sout_chg, 8'h02, "sod edges");
		chk(br, iml_pkg::IML_OKAY, "bresp ok");
		pin_cmd <= 4'h4;
		// Pin model takes one edge, filter and latch five more; two spare
		repeat (8) @(posedge CLK);
		chk(EDGE75_OUT, 1'h1, "edge masked");
		chk(IRQ, 1'h1, "irq up");
		pin_cmd <= 4'h0;
		ACK75 <= 1'h1;
		@(posedge CLK);
		ACK75 <= 1'h0;
		repeat (6) @(posedge CLK);
		chk(EDGE75_OUT, 1'h1, "edge hold");
		axr(8'h04);
		chk(rd[6], 1'h1, "readm edge");
		axr(8'h0C);
		chk(rd, 32'h1, "stat");
		axw(8'h00, 8'h10);
		chk(EDGE75_OUT, 1'h0, "edge clr");
		chk(IRQ, 1'h0, "irq clr");
		axw(8'h10, 8'h00);
		pin_cmd <= 4'hF;
		repeat (8) @(posedge CLK);
		chk(IRQ, 1'h0, "irq masked");
		chk(EDGE75_OUT, 1'h1, "edge pins");
		axr(8'h04);
		chk(rd, 32'hF7, "readm pins");
		axr(8'h0C);
		chk(rd, 32'hD, "stat pins");
		// Mask lifted, so the acknowledge may clear the latch
		axw(8'h00, 8'h08);
		ACK75 <= 1'h1;
		@(posedge CLK);
		ACK75 <= 1'h0;
		@(posedge CLK);
		chk(EDGE75_OUT, 1'h0, "edge ack");
		axr(8'h20);
		chk(rr, iml_pkg::IML_SLVERR, "unmapped");
		axw(8'h20, 8'h00);
		chk(br, iml_pkg::IML_SLVERR, "unmapped wr");
		axw(8'h08, 8'h01);
		axr(8'h04);
		chk(rd[3], 1'h1, "ie on");
		TRAP_TAKEN <= 1'h1;
		@(posedge CLK);
		TRAP_TAKEN <= 1'h0;
		axr(8'h04);
		chk(rd[3], 1'h1, "ie saved");
		chk(INT_EN_OUT, 1'h0, "ie trap");
		axr(8'h04);
		chk(rd[3], 1'h0, "ie after");
		axr(8'h0C);
		chk(rd, 32'h2, "stat trap");
		// Saved enable is one here, so only the live flag reads zero
		axw(8'h08, 8'h01);
		TRAP_TAKEN <= 1'h1;
		@(posedge CLK);
		TRAP_TAKEN <= 1'h0;
		VEC_TAKEN <= 1'h1;
		@(posedge CLK);
		VEC_TAKEN <= 1'h0;
		axr(8'h04);
		chk(rd[3], 1'h0, "ie vec");
		test_done();
	end
endmodule : iml_top_bench

bind iml_top iml_props iml_props_inst (.*);
